// file: tb/tec_pin_src.sv
// Pulse source standing in for whatever drives the two counter input pins.
// Assumes one pin is exercised at a time; the pin keeps its last level between bursts.
`timescale 1ns/1ps
module tec_pin_src (
  input  wire logic       sys_clk,
  input  wire logic       start,
  input  wire logic       sel,
  input  wire logic [3:0] n_edges,
  output logic            pin8,
  output logic            pin16,
  output logic            busy
);
  logic [3:0] left;
  logic [1:0] gap;
  initial begin
    pin8 = 1'b0;
    pin16 = 1'b0;
    left = 4'h0;
    gap = 2'h0;
  end
  // Edges are four clocks apart so the synchroniser always sees each level.
  always @(posedge sys_clk) begin
    if (start) begin
      left <= n_edges;
      gap <= 2'h0;
    end else if (left != 4'h0) begin
      gap <= gap + 2'h1;
      if (gap == 2'h3) begin
        left <= left - 4'h1;
        if (sel) pin16 <= ~pin16;
        else pin8 <= ~pin8;
      end
    end
  end
  assign busy = start || (left != 4'h0);
endmodule : tec_pin_src

// file: tb/tec_top_properties.sv
// Port-level checks for the dual counter block.
// Assumes the single sys_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module tec_top_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       counter8_input_pin,
  input wire logic       counter16_input_pin,
  input wire logic       irq_req,
  input wire logic       wake_up
);
  // One domain, so the clock and reset are named once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Two low-byte reads with a quiet cycle between them.
  sequence low_pair_s;
    (reg_rd && reg_addr == 3'h2) ##1 !(reg_rd || reg_wr) ##1 (reg_rd && reg_addr == 3'h2);
  endsequence
  AST_RST_OUT: assert property ($past(rst) |-> !irq_req && !wake_up && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_UNMAPPED_RD: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_UPPER: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[7:4] == 4'h0)
    else $error("unused interrupt bits not zero");
  AST_IRQ_MASK: assert property (reg_rd && reg_addr == 3'h5 |=>
    $past(irq_req) == |(reg_rdata[1:0] & reg_rdata[3:2])) else $error("request not flag and enable");
  AST_IRQ_CLR: assert property (reg_wr && reg_addr == 3'h5 && reg_wdata[3:2] == 2'h0
    |-> ##2 !irq_req) else $error("request while disabled");
  AST_LOW_REREAD: assert property (low_pair_s |=> reg_rdata == $past(reg_rdata, 2))
    else $error("low byte changed between reads");
  AST_LOW_WRITE: assert property ((reg_wr && reg_addr == 3'h2) ##1 !(reg_rd || reg_wr)
    ##1 (reg_rd && reg_addr == 3'h2) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("low byte buffer lost write");
  // Main scenarios: an overflow, a raised request and a buffered re-read.
  cover property (wake_up);
  cover property (irq_req);
  cover property (low_pair_s);
endmodule : tec_top_properties
bind tec_top tec_top_properties u_props (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .counter8_input_pin(counter8_input_pin), .counter16_input_pin(counter16_input_pin),
  .irq_req(irq_req), .wake_up(wake_up));

// file: tb/tec_top_tb.sv
// Self-checking bench for the dual counter, driven through its register port.
// Assumes the pulse source model drives both input pins.
`timescale 1ns/1ps
module tec_top_tb;
  logic       sys_clk, rst, reg_wr, reg_rd, start, sel, pin8, pin16, irq_req, wake_up, busy;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q, q2;
  logic [3:0] n_edges;
  int         err_count, samples_checked;
  // A 40 MHz clock.
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  tec_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter8_input_pin(pin8),
    .counter16_input_pin(pin16), .irq_req(irq_req), .wake_up(wake_up));
  tec_pin_src src (.sys_clk(sys_clk), .start(start), .sel(sel), .n_edges(n_edges),
    .pin8(pin8), .pin16(pin16), .busy(busy));
  // Shared compare, bus cycles and waits; strobes last exactly one cycle.
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask : rc
  task automatic ww();
    int i;
    for (i = 0; i < 100 && wake_up !== 1'b1; i++) @(posedge sys_clk);
    chk("wake", (i < 100) ? 8'h01 : 8'h00, 8'h01);
  endtask : ww
  task automatic pulse(input logic s, input logic [3:0] n);
    @(posedge sys_clk);
    start <= 1'b1;
    sel <= s;
    n_edges <= n;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int i = 0; i < 64 && busy; i++) @(posedge sys_clk);
    if (busy) begin
      err_count++;
      tally_and_finish();
    end
    repeat (5) @(posedge sys_clk);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Main sequence; the preload of f0 gives an overflow every sixteen ticks.
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, start, sel, n_edges} = '0;
    rst = 1'b1;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rc(a[2:0], 8'h00, "reset value");
    wr(3'h0, 8'hf0);
    rc(3'h0, 8'hf0, "stopped load");
    wr(3'h5, 8'h04);
    wr(3'h1, 8'h90);
    ww();
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", {7'h0, irq_req}, 8'h01);
    rc(3'h5, 8'h05, "flags enabled");
    wr(3'h5, 8'h00);
    ww();
    rc(3'h5, 8'h01, "flags masked");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h80);
    rd(3'h0, q);
    chk("running preload", q & 8'hf0, 8'hf0);
    rc(3'h0, q, "held count");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h50);
    pulse(1'b0, 4'h3);
    rc(3'h0, 8'h02, "rising events");
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h58);
    pulse(1'b0, 4'h3);
    rc(3'h0, 8'h02, "falling events");
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    rc(3'h3, 8'h12, "high byte");
    rc(3'h2, 8'h34, "low byte");
    rc(3'h2, 8'h34, "low reread");
    wr(3'h2, 8'h56);
    rc(3'h2, 8'h56, "low buffer");
    rc(3'h3, 8'h12, "high byte");
    rc(3'h2, 8'h34, "live low");
    wr(3'h4, 8'h50);
    pulse(1'b1, 4'h3);
    rc(3'h3, 8'h12, "wide high");
    rc(3'h2, 8'h36, "wide events");
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'hd0);
    pulse(1'b1, 4'h2);
    rc(3'h4, 8'hc0, "pulse stop");
    rc(3'h3, 8'h00, "pulse high");
    rd(3'h2, q2);
    chk("pulse width", {7'h0, q2 != 8'h00 && q2 < 8'h08}, 8'h01);
    pulse(1'b1, 4'h2);
    rc(3'h3, 8'h00, "idle high");
    rc(3'h2, q2, "ignored edges");
    tally_and_finish();
  end
endmodule : tec_top_tb

// file: verilog/tec_pkg.sv
// Package for the dual timer/event counter block.
// It holds the register offsets, field positions, mode codes and reset values.
// It assumes a plain register port with a 3-bit address and 8-bit data.
package tec_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] OFF_C8_VALUE   = 3'h0;
  localparam logic [2:0] OFF_C8_CTRL    = 3'h1;
  localparam logic [2:0] OFF_C16_LOW    = 3'h2;
  localparam logic [2:0] OFF_C16_HIGH   = 3'h3;
  localparam logic [2:0] OFF_C16_CTRL   = 3'h4;
  localparam logic [2:0] OFF_IRQ_CTRL   = 3'h5;

  // Control register fields.
  localparam int MODE_HI_BIT            = 7;
  localparam int MODE_LO_BIT            = 6;
  localparam int RUN_BIT                = 4;
  localparam int EDGE_BIT               = 3;

  // Interrupt control register fields.
  localparam int C8_FLAG_BIT            = 0;
  localparam int C16_FLAG_BIT           = 1;
  localparam int C8_IEN_BIT             = 2;
  localparam int C16_IEN_BIT            = 3;

  // Mode field codes.
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_EVENT     = 2'h1;
  localparam logic [1:0] MODE_TIMER     = 2'h2;
  localparam logic [1:0] MODE_PULSE     = 2'h3;

  // Reset values and the all-ones overflow values.
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [7:0]  C8_FULL       = 8'hff;
  localparam logic [15:0] C16_FULL      = 16'hffff;

  // Whole state of the block, registered in one place.
  typedef struct packed {
    logic [7:0]  cnt8;
    logic [7:0]  pre8;
    logic [7:0]  ctl8;
    logic [15:0] cnt16;
    logic [15:0] pre16;
    logic [7:0]  ctl16;
    logic [7:0]  low_buf;
    logic [1:0]  flags;
    logic [1:0]  ien;
    logic        act8;
    logic        act16;
    logic [2:0]  sync8;
    logic [2:0]  sync16;
    logic [7:0]  rdata;
    logic        irq;
    logic        wake;
  } tec_state_t;

endpackage : tec_pkg

// file: verilog/tec_top.sv
// Dual timer/event counter: one 8-bit and one 16-bit up-counter with preload.
// Assumes input pins synchronous to sys_clk in timing only loosely; they are
// resynchronised here. Registers sit behind a plain strobe-based port.
//
// Functional notes
// - Two independent up-counters, one 8-bit wide and one 16-bit wide.
// - Control bits 7 and 6 form the mode field.
// - Mode 1,0 is timer mode, counting every system clock.
// - Mode 0,1 is event mode, counting transitions on the input pin.
// - Run bit 4 enables counting; clear holds the count.
// - Edge bit 3 low counts rising, high counts falling pin edges.
// - Passing all ones overflows: request flag, reload from preload, keep counting.
// - Preload write while stopped also loads the counter at once.
// - Preload write while running waits for the next overflow reload.
// - 16-bit low byte write goes only into the holding buffer.
// - High byte write also moves the holding buffer into the low byte.
// - High byte read latches the live low byte into the buffer.
// - Low byte read returns the buffer, not the live low byte.
// - Overflow wakes the device; interrupt request gated by its enable bit.
// - System clock counts in timer and pulse modes; pin only in event mode.
// - Mode 1,1 measures pulse width, counting clocks during the active level.
// - Pulse end clears the run bit; later edges ignored until set again.
// - Overflow sets the request flag whether enabled or not.
// - Counting pauses during a counter read or preload write.
`timescale 1ns/1ps
module tec_top (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       counter8_input_pin,
  input  wire logic       counter16_input_pin,
  output logic            irq_req,
  output logic            wake_up
);

  tec_pkg::tec_state_t s_q;
  tec_pkg::tec_state_t s_d;

  // Decides one cycle of counting. Result is {count, active next, clear run}.
  function automatic logic [2:0] tick(input logic [7:0] ctl, input logic active,
                                      input logic rise, input logic fall);
    logic [1:0] mode;
    logic       esel;
    logic       start;
    logic       back;
    mode  = {ctl[tec_pkg::MODE_HI_BIT], ctl[tec_pkg::MODE_LO_BIT]};
    esel  = ctl[tec_pkg::EDGE_BIT];
    start = esel ? rise : fall;
    back  = esel ? fall : rise;
    tick  = 3'h0;
    if (!ctl[tec_pkg::RUN_BIT]) begin
      tick = 3'h0;
    end else begin
      case (mode)
        tec_pkg::MODE_TIMER: tick = 3'h4;
        tec_pkg::MODE_EVENT: tick = {(esel ? fall : rise), 2'h0};
        tec_pkg::MODE_PULSE: begin
          // The pin only gates the system clock here, so the pin edges start and stop it.
          if (!active) begin
            tick = {1'b0, start, 1'b0};
          end else if (back) begin
            tick = 3'h1;
          end else begin
            tick = 3'h6;
          end
        end
        default: tick = 3'h0;
      endcase
    end
  endfunction : tick

  // Next-state logic for both counters and the register port.
  always_comb begin
    logic [2:0] t8;
    logic [2:0] t16;
    logic       hold8;
    logic       hold16;
    logic       ovf8;
    logic       ovf16;
    logic       wr8;
    logic       wr16;
    t8     = 3'h0;
    t16    = 3'h0;
    hold8  = 1'b0;
    hold16 = 1'b0;
    ovf8   = 1'b0;
    ovf16  = 1'b0;
    wr8    = 1'b0;
    wr16   = 1'b0;
    s_d    = s_q;

    // Only the second and third stages feed the edge detector.
    s_d.sync8  = {s_q.sync8[1:0], counter8_input_pin};
    s_d.sync16 = {s_q.sync16[1:0], counter16_input_pin};

    t8  = tick(s_q.ctl8, s_q.act8, s_q.sync8[1] & ~s_q.sync8[2],
               ~s_q.sync8[1] & s_q.sync8[2]);
    t16 = tick(s_q.ctl16, s_q.act16, s_q.sync16[1] & ~s_q.sync16[2],
               ~s_q.sync16[1] & s_q.sync16[2]);

    // A read or preload write of a counter costs it one count, as the hardware it mirrors does.
    hold8  = (reg_rd || reg_wr) && (reg_addr == tec_pkg::OFF_C8_VALUE);
    hold16 = (reg_rd || reg_wr) && (reg_addr == tec_pkg::OFF_C16_HIGH
                                    || reg_addr == tec_pkg::OFF_C16_LOW);

    // Counting with overflow reload.
    if (t8[2] && !hold8) begin
      if (s_q.cnt8 == tec_pkg::C8_FULL) begin
        s_d.cnt8 = s_q.pre8;
        ovf8     = 1'b1;
      end else begin
        s_d.cnt8 = s_q.cnt8 + 8'h01;
      end
    end
    if (t16[2] && !hold16) begin
      if (s_q.cnt16 == tec_pkg::C16_FULL) begin
        s_d.cnt16 = s_q.pre16;
        ovf16     = 1'b1;
      end else begin
        s_d.cnt16 = s_q.cnt16 + 16'h0001;
      end
    end
    s_d.act8  = t8[1];
    s_d.act16 = t16[1];
    if (t8[0]) begin
      s_d.ctl8[tec_pkg::RUN_BIT] = 1'b0;
    end
    if (t16[0]) begin
      s_d.ctl16[tec_pkg::RUN_BIT] = 1'b0;
    end

    // Register writes; a control write by software wins over the automatic stop.
    if (reg_wr) begin
      if (reg_addr == tec_pkg::OFF_C8_VALUE) begin
        s_d.pre8 = reg_wdata;
        wr8      = 1'b1;
      end else if (reg_addr == tec_pkg::OFF_C8_CTRL) begin
        s_d.ctl8 = reg_wdata;
        s_d.act8 = 1'b0;
      end else if (reg_addr == tec_pkg::OFF_C16_LOW) begin
        s_d.low_buf = reg_wdata;
      end else if (reg_addr == tec_pkg::OFF_C16_HIGH) begin
        s_d.pre16 = {reg_wdata, s_q.low_buf};
        wr16      = 1'b1;
      end else if (reg_addr == tec_pkg::OFF_C16_CTRL) begin
        s_d.ctl16 = reg_wdata;
        s_d.act16 = 1'b0;
      end else if (reg_addr == tec_pkg::OFF_IRQ_CTRL) begin
        s_d.flags = {reg_wdata[tec_pkg::C16_FLAG_BIT], reg_wdata[tec_pkg::C8_FLAG_BIT]};
        s_d.ien   = {reg_wdata[tec_pkg::C16_IEN_BIT], reg_wdata[tec_pkg::C8_IEN_BIT]};
      end
    end
    if (wr8 && !s_q.ctl8[tec_pkg::RUN_BIT]) begin
      s_d.cnt8 = reg_wdata;
    end
    if (wr16 && !s_q.ctl16[tec_pkg::RUN_BIT]) begin
      s_d.cnt16 = {reg_wdata, s_q.low_buf};
    end

    // Overflow sets its flag even when disabled; the set wins over a clearing write.
    if (ovf8) begin
      s_d.flags[0] = 1'b1;
    end
    if (ovf16) begin
      s_d.flags[1] = 1'b1;
    end

    // Read data, valid in the cycle after the strobe only.
    s_d.rdata = tec_pkg::RST_BYTE;
    if (reg_rd) begin
      if (reg_addr == tec_pkg::OFF_C8_VALUE) begin
        s_d.rdata = s_q.cnt8;
      end else if (reg_addr == tec_pkg::OFF_C8_CTRL) begin
        s_d.rdata = s_q.ctl8;
      end else if (reg_addr == tec_pkg::OFF_C16_LOW) begin
        s_d.rdata = s_q.low_buf;
      end else if (reg_addr == tec_pkg::OFF_C16_HIGH) begin
        s_d.rdata   = s_q.cnt16[15:8];
        s_d.low_buf = s_q.cnt16[7:0];
      end else if (reg_addr == tec_pkg::OFF_C16_CTRL) begin
        s_d.rdata = s_q.ctl16;
      end else if (reg_addr == tec_pkg::OFF_IRQ_CTRL) begin
        s_d.rdata = {4'h0, s_q.ien, s_q.flags};
      end
    end

    // Wake pulses on any overflow; the request is gated by its enable.
    s_d.wake = ovf8 | ovf16;
    s_d.irq  = |(s_d.flags & s_d.ien);
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{cnt8: tec_pkg::RST_BYTE, pre8: tec_pkg::RST_BYTE, ctl8: tec_pkg::RST_BYTE,
               cnt16: tec_pkg::RST_WORD, pre16: tec_pkg::RST_WORD,
               ctl16: tec_pkg::RST_BYTE, low_buf: tec_pkg::RST_BYTE,
               flags: 2'h0, ien: 2'h0, act8: 1'b0, act16: 1'b0,
               sync8: 3'h0, sync16: 3'h0, rdata: tec_pkg::RST_BYTE,
               irq: 1'b0, wake: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata; // Straight from the flop.
  assign irq_req   = s_q.irq;
  assign wake_up   = s_q.wake;

endmodule : tec_top
